// ---- bench/line_partner.sv ----
// Far-side bus parties pulling the shared lines low
`timescale 1ns/1ps
module line_partner (
	// Pull requests: target clock, target data, host clock, host data
	input  wire logic [3:0] pull_low,
	// Line levels
	output logic            tgt_clk,
	output logic            tgt_dat,
	output logic            hst_clk,
	output logic            hst_dat
);
	// Released lines float high through pull-ups
	assign tgt_clk = !pull_low[0];
	assign tgt_dat = !pull_low[1];
	assign hst_clk = !pull_low[2];
	assign hst_dat = !pull_low[3];
endmodule

// ---- bench/smbus_ctl_props.sv ----
// Port checker for the serial bus control block
`timescale 1ns/1ps
module smbus_ctl_props
	import smbus_ctl_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
	// Clock, reset and APB
	input wire logic CLOCK,
	input wire logic RESETN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// Arbitration
	input wire logic ARB_ATTEMPT_DONE,
	input wire logic ARB_LOST,
	input wire logic ARB_RETRY,
	input wire logic ARB_ABORT,
	input wire logic ARB_PROCEED,
	// Checksum and timeouts
	input wire logic CHECKSUM_BAD,
	input wire logic CHECKSUM_ERROR,
	input wire logic HOST_CLOCK_LOW,
	input wire logic TARGET_CLOCK_LOW,
	input wire logic HOST_TIMEOUT,
	input wire logic TARGET_TIMEOUT
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RESETN);
	property p_ack; PSEL && PENABLE && !PREADY |=> PREADY; endproperty
	a_ack: assert property (p_ack) else $error("ready late");
	property p_one; PREADY |=> !PREADY; endproperty
	a_one: assert property (p_one) else $error("ready held");
	property p_err; PSLVERR |-> PREADY; endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_excl; $onehot0({ARB_RETRY, ARB_ABORT, ARB_PROCEED}); endproperty
	a_excl: assert property (p_excl) else $error("two outcomes");
	property p_loss; ARB_RETRY || ARB_ABORT |-> $past(ARB_ATTEMPT_DONE && ARB_LOST); endproperty
	a_loss: assert property (p_loss) else $error("retry without loss");
	property p_cks; $rose(CHECKSUM_ERROR) |-> $past(CHECKSUM_BAD); endproperty
	a_cks: assert property (p_cks) else $error("checksum error uncaused");
	property p_hto; $rose(HOST_TIMEOUT) |-> $past(HOST_CLOCK_LOW); endproperty
	a_hto: assert property (p_hto) else $error("host timeout uncaused");
	property p_tto; $rose(TARGET_TIMEOUT) |-> $past(TARGET_CLOCK_LOW); endproperty
	a_tto: assert property (p_tto) else $error("target timeout uncaused");
endmodule
bind smbus_ctl smbus_ctl_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) props (.CLOCK(CLOCK), .RESETN(RESETN),
	.PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .ARB_ATTEMPT_DONE(ARB_ATTEMPT_DONE),
	.ARB_LOST(ARB_LOST), .ARB_RETRY(ARB_RETRY), .ARB_ABORT(ARB_ABORT), .ARB_PROCEED(ARB_PROCEED),
	.CHECKSUM_BAD(CHECKSUM_BAD), .CHECKSUM_ERROR(CHECKSUM_ERROR), .HOST_CLOCK_LOW(HOST_CLOCK_LOW),
	.TARGET_CLOCK_LOW(TARGET_CLOCK_LOW), .HOST_TIMEOUT(HOST_TIMEOUT), .TARGET_TIMEOUT(TARGET_TIMEOUT));

// ---- bench/testbench.sv ----
// Self-checking bench for the serial bus control block
`timescale 1ns/1ps
module testbench
	import smbus_ctl_pkg::*;
;
	localparam int TO = 20;
	localparam logic [11:0] CTL = ADDR_SERIAL_BUS_CONTROL;
	logic clk = 0, rstn = 0, fast = 0, psel = 0, pen = 0, pwr = 0;
	logic done = 0, lost = 0, bad = 0, hlow = 0, tlow = 0, ev;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rv;
	logic [3:0] pull = 0;
	logic tck, tdt, hck, hdt, tcf, tdf, hcf, hdf, pclk, pready, pslverr;
	logic retry, abort, proceed, cerr, hto, tto;
	int miscompares = 0, checked = 0, cyc = 0;
	line_partner far (.pull_low(pull), .tgt_clk(tck), .tgt_dat(tdt), .hst_clk(hck), .hst_dat(hdt));
	smbus_ctl #(.TIMEOUT_CYCLES(TO)) uut (.CLOCK(clk), .RESETN(rstn), .FAST_BOOT(fast), .PSEL(psel),
		.PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .TARGET_SIDE_CLOCK_PIN(tck), .TARGET_SIDE_DATA_PIN(tdt),
		.HOST_SIDE_CLOCK_PIN(hck), .HOST_SIDE_DATA_PIN(hdt), .TARGET_CLOCK_FILTERED(tcf),
		.TARGET_DATA_FILTERED(tdf), .HOST_CLOCK_FILTERED(hcf), .HOST_DATA_FILTERED(hdf),
		.PRESCALE_CLOCK(pclk), .ARB_ATTEMPT_DONE(done), .ARB_LOST(lost), .ARB_RETRY(retry),
		.ARB_ABORT(abort), .ARB_PROCEED(proceed), .CHECKSUM_BAD(bad), .CHECKSUM_ERROR(cerr),
		.HOST_CLOCK_LOW(hlow), .TARGET_CLOCK_LOW(tlow), .HOST_TIMEOUT(hto), .TARGET_TIMEOUT(tto));
	initial begin
		forever #20 clk = ~clk;
	end
	task final_report;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			final_report;
		end
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rv = prdata;
		ev = pslverr;
		psel <= 0;
		pen <= 0;
	endtask
	task do_reset(input logic fb);
		rstn <= 0;
		fast <= fb;
		repeat (6) @(posedge clk);
		rstn <= 1;
		repeat (2) @(posedge clk);
	endtask
	task t_regs;
		do_reset(1);
		apb(0, CTL, 0);
		chk("fast default", {16'h0000, DIV_FAST}, rv);
		do_reset(0);
		apb(0, CTL, 0);
		chk("standard default", {16'h0000, DIV_STANDARD}, rv);
		apb(1, CTL, 32'hFFFFFFFF);
		chk("mapped error", 0, ev);
		apb(0, CTL, 0);
		chk("control readback", 32'h007FFFFF, rv);
		apb(0, 12'h500, 0);
		chk("unmapped data", 0, rv);
		chk("unmapped error", 1, ev);
	endtask
	task t_prescale;
		int lo, hi;
		// Ten 32 ns ticks span exactly eight 40 ns clocks
		apb(1, CTL, 32'h0000000A);
		do @(posedge clk); while (pclk !== 1'b1);
		do @(posedge clk); while (pclk !== 1'b0);
		lo = 0;
		while (pclk === 1'b0) begin lo++; @(posedge clk); end
		hi = 0;
		while (pclk === 1'b1) begin hi++; @(posedge clk); end
		chk("low time", 4, lo);
		chk("period", 8, lo + hi);
		for (int d = 0; d < 2; d++) begin
			apb(1, CTL, d);
			lo = 0;
			repeat (12) begin @(posedge clk); lo += (pclk !== 1'b1); end
			chk("stopped", 0, lo);
		end
	endtask
	task attempt(input logic l);
		@(posedge clk);
		done <= 1;
		lost <= l;
		@(posedge clk);
		done <= 0;
		@(posedge clk);
	endtask
	task t_arb;
		apb(1, CTL, 0);
		for (int i = 1; i <= 16; i++) begin
			attempt(1);
			chk("abort", i == 16, abort);
			chk("retry", i != 16, retry);
		end
		apb(0, ADDR_LINK_STATUS, 0);
		chk("lost flag", 1, rv[0]);
		chk("loss count reset", 0, rv[12:8]);
		apb(1, ADDR_LINK_STATUS, 32'h00000001);
		apb(0, ADDR_LINK_STATUS, 0);
		chk("lost flag cleared", 0, rv[0]);
		attempt(1);
		attempt(1);
		apb(0, ADDR_LINK_STATUS, 0);
		chk("loss count", 2, rv[12:8]);
		apb(1, CTL, 32'h00010000);
		attempt(1);
		chk("proceed", 1, proceed);
		chk("no retry", 0, retry);
	endtask
	task t_cksum;
		for (int b = 1; b >= 0; b--) begin
			apb(1, CTL, b << CKSUM_BYP_BIT);
			attempt(0);
			bad <= 1;
			@(posedge clk);
			bad <= 0;
			repeat (3) @(posedge clk);
			chk("checksum error", !b, cerr);
		end
		apb(1, ADDR_LINK_STATUS, 32'h00000002);
		chk("checksum cleared", 0, cerr);
	endtask
	task t_filter;
		int n, e;
		for (int s = 0; s < 2; s++) for (int m = 0; m < 3; m++) begin
			e = (m == 0) ? FILT_SLOW_CYC : (m == 1) ? FILT_FAST_CYC : 0;
			apb(1, CTL, m << (s ? HOST_FILT_LSB : TGT_FILT_LSB));
			pull <= s ? 4'hC : 4'h3;
			n = 0;
			do begin @(posedge clk); n++; end while ((s ? {hcf, hdf} : {tcf, tdf}) !== 2'b00 && n < 60);
			chk("filter delay", 1, n >= e && n <= e + 4);
			pull <= 0;
			repeat (40) @(posedge clk);
		end
	endtask
	task t_timeout;
		for (int k = 0; k < 2; k++) begin
			do_reset(0);
			apb(1, CTL, k << TIMEOUT_OFF_BIT);
			hlow <= 1;
			tlow <= 1;
			repeat (TO + 10) @(posedge clk);
			chk("host timeout", !k, hto);
			chk("target timeout", !k, tto);
			hlow <= 0;
			tlow <= 0;
		end
	endtask
	initial begin
		t_regs;
		t_prescale;
		t_arb;
		t_cksum;
		t_filter;
		t_timeout;
		final_report;
	end
endmodule

// ---- hw/glitch_filter.sv ----
// Two-line glitch filter with selectable settle time
`timescale 1ns/1ps
module glitch_filter
	import smbus_ctl_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Setting and lines
	input  wire logic [1:0] mode,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            scl_out,
	output logic            sda_out
);
	typedef struct packed {
		logic       scl;
		logic       sda;
		logic [7:0] scl_cnt;
		logic [7:0] sda_cnt;
	} filt_state_t;

	filt_state_t s_q;
	filt_state_t s_d;
	logic [7:0]  limit;

	always_comb begin
		s_d = s_q;
		limit = (mode == FILT_QUICK) ? FILT_FAST_CYC : FILT_SLOW_CYC;
		if (mode == FILT_OFF) begin // R10
			s_d.scl = scl_in;
			s_d.sda = sda_in;
			s_d.scl_cnt = 8'h00;
			s_d.sda_cnt = 8'h00;
		end else begin
			// Level must stay changed for the full settle time
			if (scl_in == s_q.scl) begin
				s_d.scl_cnt = 8'h00;
			end else if (s_q.scl_cnt + 8'h01 >= limit) begin // R08
				s_d.scl = scl_in;
				s_d.scl_cnt = 8'h00;
			end else begin
				s_d.scl_cnt = s_q.scl_cnt + 8'h01;
			end
			if (sda_in == s_q.sda) begin
				s_d.sda_cnt = 8'h00;
			end else if (s_q.sda_cnt + 8'h01 >= limit) begin // R08
				s_d.sda = sda_in;
				s_d.sda_cnt = 8'h00;
			end else begin
				s_d.sda_cnt = s_q.sda_cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{scl: 1'b1, sda: 1'b1, scl_cnt: 8'h00, sda_cnt: 8'h00};
		end else begin
			s_q <= s_d;
		end
	end

	assign scl_out = s_q.scl;
	assign sda_out = s_q.sda;
endmodule

// ---- hw/smbus_ctl.sv ----
// Serial bus control register, prescaler, filters and timeout gating
// Functional notes
// R01 - Prescaler period is 32 ns times the 16-bit divider value.
// R02 - Divider of zero or one stops the prescaler clock.
// R03 - Standard-speed boot strap loads divider 0x0139.
// R04 - Fast boot strap loads divider 0x53, about 376 kHz.
// R05 - Master clock stays low for half the programmed period.
// R06 - Ignore bit lets master continue after losing arbitration.
// R07 - Bypass bit makes the EEPROM checksum always pass.
// R08 - Filter delay applies to clock and data before use.
// R09 - Target filter: 0 about 1 us, 1 100 ns, 2 none.
// R10 - Host filter: 0 about 1 us, 1 100 ns, 2 none.
// R11 - Timeout-off bit suppresses timeouts on both sides; resets zero.
// R12 - Otherwise retry arbitration, abort after 16 losses, flag error.
// R13 - Prescaler counts 32 ns ticks, reloading from divider each period.
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
module smbus_ctl
	import smbus_ctl_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
	// Clock and reset
	input  wire logic        CLOCK,
	input  wire logic        RESETN,
	// Boot strap
	input  wire logic        FAST_BOOT,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// Filtered bus lines
	input  wire logic        TARGET_SIDE_CLOCK_PIN,
	input  wire logic        TARGET_SIDE_DATA_PIN,
	input  wire logic        HOST_SIDE_CLOCK_PIN,
	input  wire logic        HOST_SIDE_DATA_PIN,
	output logic             TARGET_CLOCK_FILTERED,
	output logic             TARGET_DATA_FILTERED,
	output logic             HOST_CLOCK_FILTERED,
	output logic             HOST_DATA_FILTERED,
	// Master clock output
	output logic             PRESCALE_CLOCK,
	// Arbitration
	input  wire logic        ARB_ATTEMPT_DONE,
	input  wire logic        ARB_LOST,
	output logic             ARB_RETRY,
	output logic             ARB_ABORT,
	output logic             ARB_PROCEED,
	// Checksum
	input  wire logic        CHECKSUM_BAD,
	output logic             CHECKSUM_ERROR,
	// Timeouts
	input  wire logic        HOST_CLOCK_LOW,
	input  wire logic        TARGET_CLOCK_LOW,
	output logic             HOST_TIMEOUT,
	output logic             TARGET_TIMEOUT
);
	typedef struct packed {
		logic        strap_done;
		logic [15:0] divider;
		logic        ign_arb;
		logic        cksum_byp;
		logic [1:0]  tgt_filt;
		logic [1:0]  host_filt;
		logic        timeout_off;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic [4:0]  base_cnt;
		logic [15:0] tick_cnt;
		logic        pclk;
		logic [4:0]  arb_losses;
		logic        arb_retry;
		logic        arb_abort;
		logic        arb_proceed;
		logic        arb_err;
		logic        cksum_err;
		logic [31:0] host_to_cnt;
		logic [31:0] tgt_to_cnt;
		logic        host_to;
		logic        tgt_to;
	} ctl_state_t;

	localparam logic [6:0] BASE_STEP = 7'(BASE_TICK_NS);
	localparam logic [6:0] CLK_STEP  = 7'(CLOCK_PERIOD_NS);

	ctl_state_t s_q;
	ctl_state_t s_d;
	logic       wr_en;
	logic       rd_en;
	logic       reg_hit;
	logic       stat_hit;
	logic [1:0]  ticks;
	logic [6:0]  base_sum;
	logic [16:0] tick_sum;
	logic [15:0] half;

	always_comb begin
		s_d = s_q;
		wr_en = PSEL && PENABLE && PWRITE && !s_q.pready;
		rd_en = PSEL && PENABLE && !PWRITE && !s_q.pready;
		reg_hit = (PADDR == ADDR_SERIAL_BUS_CONTROL);
		stat_hit = (PADDR == ADDR_LINK_STATUS);
		s_d.pready = PSEL && PENABLE && !s_q.pready;
		s_d.pslverr = PSEL && PENABLE && !s_q.pready && !reg_hit && !stat_hit;
		// Boot strap captured once after reset release
		if (!s_q.strap_done) begin
			s_d.strap_done = 1'b1;
			s_d.divider = FAST_BOOT ? DIV_FAST : DIV_STANDARD; // R03 R04
		end
		if (wr_en && reg_hit) begin
			s_d.divider = PWDATA[DIV_MSB:DIV_LSB];
			s_d.ign_arb = PWDATA[IGN_ARB_BIT];
			s_d.cksum_byp = PWDATA[CKSUM_BYP_BIT];
			s_d.tgt_filt = PWDATA[TGT_FILT_LSB +: 2];
			s_d.host_filt = PWDATA[HOST_FILT_LSB +: 2];
			s_d.timeout_off = PWDATA[TIMEOUT_OFF_BIT];
		end
		if (rd_en) begin
			s_d.prdata = 32'h0000_0000;
			if (reg_hit) begin
				s_d.prdata[DIV_MSB:DIV_LSB] = s_q.divider;
				s_d.prdata[IGN_ARB_BIT] = s_q.ign_arb;
				s_d.prdata[CKSUM_BYP_BIT] = s_q.cksum_byp;
				s_d.prdata[TGT_FILT_LSB +: 2] = s_q.tgt_filt;
				s_d.prdata[HOST_FILT_LSB +: 2] = s_q.host_filt;
				s_d.prdata[TIMEOUT_OFF_BIT] = s_q.timeout_off;
			end else if (stat_hit) begin
				s_d.prdata[0] = s_q.arb_err;
				s_d.prdata[1] = s_q.cksum_err;
				s_d.prdata[2] = s_q.host_to;
				s_d.prdata[3] = s_q.tgt_to;
				s_d.prdata[8 +: 5] = s_q.arb_losses;
			end
		end
		// Whole 32 ns ticks in one clock period, remainder carried on
		base_sum = {2'b00, s_q.base_cnt} + CLK_STEP;
		if (base_sum >= BASE_STEP + BASE_STEP) begin
			ticks = 2'h2;
			s_d.base_cnt = 5'(base_sum - BASE_STEP - BASE_STEP);
		end else if (base_sum >= BASE_STEP) begin
			ticks = 2'h1;
			s_d.base_cnt = 5'(base_sum - BASE_STEP);
		end else begin
			ticks = 2'h0;
			s_d.base_cnt = 5'(base_sum);
		end // R13
		// Very small dividers alias against the clock; edges land on clock edges
		half = {1'b0, s_q.divider[15:1]};
		tick_sum = {1'b0, s_q.tick_cnt} + {15'h0000, ticks};
		if (s_q.divider <= 16'h0001) begin // R02
			s_d.tick_cnt = 16'h0000;
			s_d.pclk = 1'b1;
		end else begin
			if (s_q.tick_cnt >= s_q.divider) begin
				// Divider lowered below the running count
				s_d.tick_cnt = 16'h0000;
			end else if (tick_sum >= {1'b0, s_q.divider}) begin // R01 R13
				s_d.tick_cnt = 16'(tick_sum - {1'b0, s_q.divider});
			end else begin
				s_d.tick_cnt = 16'(tick_sum);
			end
			s_d.pclk = (s_d.tick_cnt >= half); // R05
		end
		// Arbitration handling
		s_d.arb_retry = 1'b0;
		s_d.arb_abort = 1'b0;
		s_d.arb_proceed = 1'b0;
		if (ARB_ATTEMPT_DONE) begin
			if (!ARB_LOST || s_q.ign_arb) begin // R06
				s_d.arb_proceed = 1'b1;
				s_d.arb_losses = 5'h00;
			end else if (s_q.arb_losses + 5'h01 >= ARB_LIMIT) begin // R12
				s_d.arb_abort = 1'b1;
				s_d.arb_err = 1'b1;
				s_d.arb_losses = 5'h00;
			end else begin
				s_d.arb_retry = 1'b1; // R12
				s_d.arb_losses = s_q.arb_losses + 5'h01;
			end
		end
		if (wr_en && stat_hit && PWDATA[0] && !(ARB_ATTEMPT_DONE && ARB_LOST && !s_q.ign_arb)) begin
			s_d.arb_err = s_d.arb_abort;
		end
		s_d.cksum_err = (CHECKSUM_BAD && !s_q.cksum_byp) || s_q.cksum_err; // R07
		if (wr_en && stat_hit && PWDATA[1] && !(CHECKSUM_BAD && !s_q.cksum_byp)) begin
			s_d.cksum_err = 1'b0;
		end
		// Clock-low timeouts
		if (s_q.timeout_off || !HOST_CLOCK_LOW) begin // R11
			s_d.host_to_cnt = 32'h0;
			s_d.host_to = 1'b0;
		end else if (s_q.host_to_cnt >= 32'(TIMEOUT_CYCLES)) begin
			s_d.host_to = 1'b1;
		end else begin
			s_d.host_to_cnt = s_q.host_to_cnt + 32'h1;
		end
		if (s_q.timeout_off || !TARGET_CLOCK_LOW) begin // R11
			s_d.tgt_to_cnt = 32'h0;
			s_d.tgt_to = 1'b0;
		end else if (s_q.tgt_to_cnt >= 32'(TIMEOUT_CYCLES)) begin
			s_d.tgt_to = 1'b1;
		end else begin
			s_d.tgt_to_cnt = s_q.tgt_to_cnt + 32'h1;
		end
	end

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			s_q <= '0;
			s_q.divider <= DIV_STANDARD;
			s_q.pclk <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	logic t_scl;
	logic t_sda;
	logic h_scl;
	logic h_sda;

	glitch_filter u_target_filter ( // R09 R08
		.clk     (CLOCK),
		.rst_n   (RESETN),
		.mode    (s_q.tgt_filt),
		.scl_in  (TARGET_SIDE_CLOCK_PIN),
		.sda_in  (TARGET_SIDE_DATA_PIN),
		.scl_out (t_scl),
		.sda_out (t_sda)
	);

	glitch_filter u_host_filter ( // R10 R08
		.clk     (CLOCK),
		.rst_n   (RESETN),
		.mode    (s_q.host_filt),
		.scl_in  (HOST_SIDE_CLOCK_PIN),
		.sda_in  (HOST_SIDE_DATA_PIN),
		.scl_out (h_scl),
		.sda_out (h_sda)
	);

	assign TARGET_CLOCK_FILTERED = t_scl;
	assign TARGET_DATA_FILTERED  = t_sda;
	assign HOST_CLOCK_FILTERED   = h_scl;
	assign HOST_DATA_FILTERED    = h_sda;
	assign PRDATA                = s_q.prdata;
	assign PREADY                = s_q.pready;
	assign PSLVERR               = s_q.pslverr;
	assign PRESCALE_CLOCK        = s_q.pclk;
	assign ARB_RETRY             = s_q.arb_retry;
	assign ARB_ABORT             = s_q.arb_abort;
	assign ARB_PROCEED           = s_q.arb_proceed;
	assign CHECKSUM_ERROR        = s_q.cksum_err;
	assign HOST_TIMEOUT          = s_q.host_to;
	assign TARGET_TIMEOUT        = s_q.tgt_to;
endmodule

// ---- hw/smbus_ctl_pkg.sv ----
// Constants for the serial bus control block
package smbus_ctl_pkg;
	localparam logic [11:0] ADDR_SERIAL_BUS_CONTROL = 12'h428;
	localparam logic [11:0] ADDR_LINK_STATUS        = 12'h42C;
	localparam int          DIV_LSB                 = 0;
	localparam int          DIV_MSB                 = 15;
	localparam int          IGN_ARB_BIT             = 16;
	localparam int          CKSUM_BYP_BIT           = 17;
	localparam int          TGT_FILT_LSB            = 18;
	localparam int          HOST_FILT_LSB           = 20;
	localparam int          TIMEOUT_OFF_BIT         = 22;
	localparam logic [15:0] DIV_STANDARD            = 16'h0139;
	localparam logic [15:0] DIV_FAST                = 16'h0053;
	localparam int          CLOCK_PERIOD_NS         = 40;
	localparam int          BASE_TICK_NS            = 32;
	localparam int          FILT_SLOW_NS            = 1000;
	localparam int          FILT_FAST_NS            = 100;
	localparam logic [7:0]  FILT_SLOW_CYC           = 8'((FILT_SLOW_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
	localparam logic [7:0]  FILT_FAST_CYC           = 8'((FILT_FAST_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
	localparam logic [1:0]  FILT_NORMAL             = 2'h0;
	localparam logic [1:0]  FILT_QUICK              = 2'h1;
	localparam logic [1:0]  FILT_OFF                = 2'h2;
	localparam logic [4:0]  ARB_LIMIT               = 5'h10;
	localparam int          TIMEOUT_US              = 25;
	localparam int          TIMEOUT_CYC             = TIMEOUT_US * 1000 / CLOCK_PERIOD_NS;
endpackage
